// *** lpp_pkg.sv ***
// Package for the parallel host port of the dot-matrix display controller.
// Assumes a single 10 MHz system clock and synchronous pin inputs.
`default_nettype none

package lpp_pkg;

    // ****************************************************************
    // Bus widths and style codes
    // ****************************************************************
    localparam int unsigned DATA_W      = 8;
    localparam logic        STYLE_8080  = 1'b0;
    localparam logic        STYLE_6800  = 1'b1;
    localparam logic        DIR_READ    = 1'b1;
    localparam logic        SEL_DISPLAY = 1'b1;

    // ****************************************************************
    // Reset values and instruction codes
    // ****************************************************************
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [7:0]  RST_READ    = 8'h00;
    localparam logic [7:0]  CMD_SW_RST  = 8'hE2;

    // One-hot port state: idle, completed write strobe, or read
    typedef enum logic [2:0] {
        LPP_IDLE  = 3'b001,
        LPP_WRITE = 3'b010,
        LPP_READ  = 3'b100
    } lpp_state_t;

endpackage : lpp_pkg

`default_nettype wire

// *** lpp_strobe_if.sv ***
// Interface carrying decoded strobe events from the decoder to the port.
// Assumes both ends sit on sys_clk.
`default_nettype none

interface lpp_strobe_if;
    logic       wr_done;
    logic       rd_active;
    logic [7:0] wr_byte;
    logic       wr_sel;

    modport decoder (output wr_done, output rd_active,
                     output wr_byte, output wr_sel);
    modport port    (input wr_done, input rd_active,
                     input wr_byte, input wr_sel);
endinterface : lpp_strobe_if

`default_nettype wire

// *** lpp_strobe_dec.sv ***
// Strobe decoder: turns raw bus pins into write-done pulses and read level.
// Assumes pins are synchronous to sys_clk.
`default_nettype none

module lpp_strobe_dec
    import lpp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       chip_select_n,
    input  wire logic       host_bus_style_select,
    input  wire logic       enable_or_fetch_strobe,
    input  wire logic       direction_or_store_strobe,
    input  wire logic       cmd_data_select,
    input  wire logic [7:0] host_data_lines_in,
    lpp_strobe_if.decoder   dec
);
    logic       en_prev_ff,  nxt_en_prev;
    logic       wr_prev_ff,  nxt_wr_prev;
    logic [7:0] byte_ff,     nxt_byte;
    logic       sel_ff,      nxt_sel;
    logic       is6800;

    // ****************************************************************
    // Byte tracking on every cycle
    // ****************************************************************
    always_comb begin
        is6800      = (host_bus_style_select == STYLE_6800);
        nxt_en_prev = enable_or_fetch_strobe & ~chip_select_n;
        nxt_wr_prev = ~direction_or_store_strobe & ~chip_select_n;
        // Register a sample every cycle so the edge uses the previous cycle's byte
        nxt_byte    = host_data_lines_in;
        nxt_sel     = cmd_data_select;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            en_prev_ff <= 1'b0;
            wr_prev_ff <= 1'b0;
            byte_ff    <= RST_BYTE;
            sel_ff     <= 1'b0;
        end else begin
            en_prev_ff <= nxt_en_prev;
            wr_prev_ff <= nxt_wr_prev;
            byte_ff    <= nxt_byte;
            sel_ff     <= nxt_sel;
        end
    end

    // Falling E in 6800 write, rising /WR in 8080
    assign dec.wr_done = is6800
        ? (en_prev_ff & ~enable_or_fetch_strobe
           & (direction_or_store_strobe != DIR_READ))
        : (wr_prev_ff & direction_or_store_strobe);
    assign dec.wr_byte = byte_ff;
    assign dec.wr_sel  = sel_ff;
    assign dec.rd_active = ~chip_select_n & (is6800
        ? (enable_or_fetch_strobe & (direction_or_store_strobe == DIR_READ))
        : ~enable_or_fetch_strobe);

endmodule : lpp_strobe_dec // lpp_strobe_dec

`default_nettype wire

// *** lpp_port.sv ***
// Parallel host port: 6800/8080 bus front end of the display controller.
// Assumes synchronous pins and an external tristate resolver on the data bus.
`default_nettype none

// Summary of operation
// - Accesses happen only with chip select low; otherwise bus ignored, undriven.
// - Select high means display data, low means command byte.
// - Eight-bit two-way data bus, sampled on writes, driven only on reads.
// - Style strap low gives 8080 strobes, high gives 6800 strobes.
// - In 6800 style direction high reads, low writes.
// - 6800 read drives the bus while enable is high.
// - 6800 write captures the byte at falling enable.
// - 8080 read drives the bus while read strobe is low.
// - Hardware reset low initializes the whole port.
// - Software reset restores line, column, page, direction; keeps RAM. The port only pulses soft_reset on command byte E2.
module lpp_port
    import lpp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       hardware_reset_n,
    input  wire logic       chip_select_n,
    input  wire logic       host_bus_style_select,
    input  wire logic       enable_or_fetch_strobe,
    input  wire logic       direction_or_store_strobe,
    input  wire logic       cmd_data_select,
    input  wire logic [7:0] host_data_lines_in,
    output logic      [7:0] host_data_lines_out,
    output logic            host_data_lines_oe,
    input  wire logic [7:0] read_byte,
    output logic            cmd_valid,
    output logic      [7:0] cmd_byte,
    output logic            disp_valid,
    output logic      [7:0] disp_byte,
    output logic            soft_reset
);
    import lpp_pkg::*;

    lpp_strobe_if sif ();
    logic       rst_all_n;
    assign rst_all_n = nrst & hardware_reset_n;

    lpp_strobe_dec u_dec (
        .sys_clk                   (sys_clk),
        .nrst                      (rst_all_n),
        .chip_select_n             (chip_select_n),
        .host_bus_style_select     (host_bus_style_select),
        .enable_or_fetch_strobe    (enable_or_fetch_strobe),
        .direction_or_store_strobe (direction_or_store_strobe),
        .cmd_data_select           (cmd_data_select),
        .host_data_lines_in        (host_data_lines_in),
        .dec                       (sif)
    );

    // ****************************************************************
    // Port state
    // ****************************************************************
    lpp_state_t state_ff, nxt_state;
    logic [7:0] dout_ff,  nxt_dout;
    logic       oe_ff,    nxt_oe;
    logic       cv_ff,    nxt_cv;
    logic       dv_ff,    nxt_dv;
    logic [7:0] cb_ff,    nxt_cb;
    logic [7:0] db_ff,    nxt_db;
    logic       sr_ff,    nxt_sr;

    always_comb begin
        nxt_dout  = dout_ff;
        nxt_cb    = cb_ff;
        nxt_db    = db_ff;
        nxt_cv    = 1'b0;
        nxt_dv    = 1'b0;
        nxt_sr    = 1'b0;
        nxt_oe    = sif.rd_active;
        nxt_state = LPP_IDLE;
        if (sif.rd_active) begin
            nxt_state = LPP_READ;
            nxt_dout  = read_byte;
        end else if (sif.wr_done) begin
            nxt_state = LPP_WRITE;
            if (sif.wr_sel == SEL_DISPLAY) begin
                nxt_dv = 1'b1;
                nxt_db = sif.wr_byte;
            end else begin
                nxt_cv = 1'b1;
                nxt_cb = sif.wr_byte;
                // Soft reset leaves display RAM alone downstream
                nxt_sr = (sif.wr_byte == CMD_SW_RST);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_all_n) begin
        if (!rst_all_n) begin
            state_ff <= LPP_IDLE;
            dout_ff  <= RST_READ;
            oe_ff    <= 1'b0;
            cv_ff    <= 1'b0;
            dv_ff    <= 1'b0;
            cb_ff    <= RST_BYTE;
            db_ff    <= RST_BYTE;
            sr_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            dout_ff  <= nxt_dout;
            oe_ff    <= nxt_oe;
            cv_ff    <= nxt_cv;
            dv_ff    <= nxt_dv;
            cb_ff    <= nxt_cb;
            db_ff    <= nxt_db;
            sr_ff    <= nxt_sr;
        end
    end

    assign host_data_lines_out = dout_ff;
    assign host_data_lines_oe  = oe_ff;
    assign cmd_valid           = cv_ff;
    assign cmd_byte            = cb_ff;
    assign disp_valid          = dv_ff;
    assign disp_byte           = db_ff;
    assign soft_reset          = sr_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_desel_no_drive: assert property (@(posedge sys_clk)
        disable iff (!rst_all_n)
        $past(chip_select_n) |-> !host_data_lines_oe)
        else $error("bus driven while deselected");
    a_desel_no_write: assert property (@(posedge sys_clk)
        disable iff (!rst_all_n)
        $past(chip_select_n, 2) && $past(chip_select_n)
        |-> !(cmd_valid || disp_valid))
        else $error("write taken while deselected");
    a_disp_route: assert property (@(posedge sys_clk)
        disable iff (!rst_all_n)
        disp_valid |-> !cmd_valid && $past(sif.wr_sel))
        else $error("display byte misrouted");
    a_cmd_route: assert property (@(posedge sys_clk)
        disable iff (!rst_all_n)
        cmd_valid |-> cmd_byte == $past(sif.wr_byte))
        else $error("command byte wrong");
    a_read_6800: assert property (@(posedge sys_clk)
        disable iff (!rst_all_n)
        host_bus_style_select && !chip_select_n
        && enable_or_fetch_strobe && direction_or_store_strobe
        |=> host_data_lines_oe)
        else $error("6800 read not driven");
    a_read_8080: assert property (@(posedge sys_clk)
        disable iff (!rst_all_n)
        !host_bus_style_select && !chip_select_n && !enable_or_fetch_strobe
        |=> host_data_lines_oe ##0 host_data_lines_out == $past(read_byte))
        else $error("8080 read not driven");
    a_write_6800: assert property (@(posedge sys_clk)
        disable iff (!rst_all_n)
        host_bus_style_select && !chip_select_n
        && enable_or_fetch_strobe && !direction_or_store_strobe
        ##1 !enable_or_fetch_strobe && !direction_or_store_strobe
        |=> cmd_valid || disp_valid)
        else $error("6800 write not captured");
    a_write_8080: assert property (@(posedge sys_clk)
        disable iff (!rst_all_n)
        !host_bus_style_select && !chip_select_n
        && !direction_or_store_strobe && enable_or_fetch_strobe
        ##1 direction_or_store_strobe && enable_or_fetch_strobe
        |=> cmd_valid || disp_valid)
        else $error("8080 write not captured");
    a_soft_reset: assert property (@(posedge sys_clk)
        disable iff (!rst_all_n)
        soft_reset |-> cmd_valid && cmd_byte == CMD_SW_RST)
        else $error("soft reset without command");
    a_hw_reset: assert property (@(posedge sys_clk)
        $rose(rst_all_n) |-> !host_data_lines_oe && !cmd_valid)
        else $error("outputs not cleared by reset");
    a_state_track: assert property (@(posedge sys_clk)
        disable iff (!rst_all_n)
        host_data_lines_oe == (state_ff == LPP_READ)
        && (cmd_valid || disp_valid) == (state_ff == LPP_WRITE))
        else $error("port state out of step");

endmodule : lpp_port // lpp_port

`default_nettype wire

// *** lpp_host_model.sv ***
// Host processor model that drives the parallel port pins.
// Assumes the bench resolves the data bus from both drive enables.
`default_nettype none

module lpp_host_model (
    input  wire logic       sys_clk,
    output var  logic       cs_n,
    output var  logic       style,
    output var  logic       strb_a,
    output var  logic       strb_b,
    output var  logic       sel,
    output var  logic [7:0] hd,
    output var  logic       hd_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Bus cycles, all changes on the falling edge
    // ****************************************************************
    // Style changes only while deselected, strobes parked inactive
    task automatic idle(input logic s);
        cs_n   = 1'b1;
        style  = s;
        strb_a = ~s;
        strb_b = 1'b1;
        hd_oe  = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic wr(input logic c, input logic s, input logic [7:0] d);
        @(negedge sys_clk);
        cs_n   = c;
        sel    = s;
        hd     = d;
        hd_oe  = 1'b1;
        strb_b = 1'b0;
        // E high in 6800; read strobe must stay parked high in 8080
        strb_a = 1'b1;
        @(negedge sys_clk);
        if (style) strb_a = 1'b0;
        else strb_b = 1'b1;
        @(negedge sys_clk);
        cs_n   = 1'b1;
        hd_oe  = 1'b0;
        strb_b = 1'b1;
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic c, input int n);
        @(negedge sys_clk);
        cs_n   = c;
        strb_b = 1'b1;
        strb_a = style;
        repeat (n) @(negedge sys_clk);
        strb_a = ~style;
        cs_n   = 1'b1;
        @(negedge sys_clk);
    endtask
    initial begin
        hd  = 8'h00;
        sel = 1'b0;
        idle(1'b0);
    end
endmodule // lpp_host_model

`default_nettype wire

// *** test_lcd_parallel_mpu_port.sv ***
// Self-checking bench for the parallel host port.
// Assumes the host model and the design files are compiled before it.
`default_nettype none

module test_lcd_parallel_mpu_port;
    timeunit 1ns;
    timeprecision 1ns;
    import lpp_pkg::*;
    logic       sys_clk, nrst, hw_n, cs_n, style, sa, sb, sel, hd_oe;
    logic       doe, cv, dv, sr, oe_q;
    logic [7:0] hd, bus, rb, dout, cb, db;
    logic [7:0] float_q = 8'h00;
    logic [10:0] sw;
    logic [10:0] wq[$];
    logic [7:0]  rq[$];
    int          fail_count, comparisons, seed;
    // Released bus wanders so a stale value never looks valid
    assign bus = doe ? dout : (hd_oe ? hd : float_q);
    lpp_host_model host (.sys_clk(sys_clk), .cs_n(cs_n), .style(style),
        .strb_a(sa), .strb_b(sb), .sel(sel), .hd(hd), .hd_oe(hd_oe));
    lpp_port dut (.sys_clk(sys_clk), .nrst(nrst), .hardware_reset_n(hw_n),
        .chip_select_n(cs_n), .host_bus_style_select(style),
        .enable_or_fetch_strobe(sa), .direction_or_store_strobe(sb),
        .cmd_data_select(sel), .host_data_lines_in(bus),
        .host_data_lines_out(dout), .host_data_lines_oe(doe),
        .read_byte(rb), .cmd_valid(cv), .cmd_byte(cb), .disp_valid(dv),
        .disp_byte(db), .soft_reset(sr));
    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) float_q <= float_q + 8'h3b;
    // ****************************************************************
    // Comparison, scoreboard and closing
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("fail_count %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(negedge sys_clk) begin
        if (cv === 1'b1 || dv === 1'b1) begin
            sw = {cv, dv, sr, dv ? db : cb};
            if (wq.size() == 0) check(16'h0001, 16'h0000);
            else begin
                check(sw, wq.pop_front());
            end
        end
        if (doe === 1'b1 && oe_q !== 1'b1) begin
            if (rq.size() == 0) check(16'h0002, 16'h0000);
            else begin
                check(dout, rq.pop_front());
            end
        end
        oe_q = doe;
    end
    // ****************************************************************
    // Stimulus
    // ****************************************************************
    task automatic w(input logic c, input logic s, input logic [7:0] d);
        if (!c) wq.push_back({~s, s, !s && d == CMD_SW_RST, d});
        host.wr(c, s, d);
    endtask
    task automatic r(input logic c, input logic [7:0] v);
        rb = v;
        if (!c) rq.push_back(v);
        host.rd(c, 3);
        @(negedge sys_clk);
        check(doe, 1'b0);
    endtask
    initial begin
        #200_000;
        fail_count++;
        finish_test();
    end
    initial begin
        logic [7:0] d;
        fail_count  = 0;
        comparisons = 0;
        seed = 32'h7ae1;
        nrst = 1'b0;
        hw_n = 1'b1;
        rb   = 8'h00;
        repeat (5) @(negedge sys_clk);
        nrst = 1'b1;
        for (int m = 0; m < 2; m++) begin
            host.idle(m[0]);
            w(1'b0, 1'b0, CMD_SW_RST);
            for (int i = 0; i < 6; i++) begin
                d = 8'($random(seed));
                w(1'b0, i[0], d);
            end
            w(1'b1, 1'b0, CMD_SW_RST);
            d = 8'($random(seed));
            r(1'b0, d);
            r(1'b1, ~d);
        end
        w(1'b0, 1'b1, 8'hc3);
        hw_n = 1'b0;
        @(negedge sys_clk);
        check({cb, db}, 16'h0000);
        hw_n = 1'b1;
        w(1'b0, 1'b0, 8'h11);
        check(16'(wq.size() + rq.size()), 16'h0000);
        finish_test();
    end
endmodule // test_lcd_parallel_mpu_port

`default_nettype wire
